// [flash_front_pkg.sv]
package flash_front_pkg;

	localparam int CLK_PERIOD_PS = 8000;
	// Unlock spacing, nominal figure; spread is +/-20 us
	localparam int UNLOCK_DELAY_US = 100;
	localparam int UNLOCK_CYC_DEF = (UNLOCK_DELAY_US * 1000 * 1000) / CLK_PERIOD_PS;
	localparam int PROG_TIME_NS = 1000;
	localparam int PROG_CYC_INT = (PROG_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [7:0] PROG_CYC = 8'(PROG_CYC_INT);
	localparam int RATE_W = 14;

	localparam logic [1:0] MODE_DEFAULT = 2'h3;
	localparam logic [1:0] MODE_PERSIST = 2'h2;
	localparam logic [1:0] MODE_PASSWORD = 2'h1;
	localparam logic [1:0] MODE_ILLEGAL = 2'h0;
	localparam int MODE_SEL_POS = 1;
	localparam logic [63:0] ALL_ONES = 64'hFFFF_FFFF_FFFF_FFFF;

	localparam int ST_WIP_BIT = 0;
	localparam int ST_PERR_BIT = 6;
	localparam logic [3:0] CONT_MODE_CODE = 4'hA;

	localparam logic [6:0] INSTR_BITS = 7'h08;
	localparam logic [6:0] MODE_BITS = 7'h08;
	localparam logic [6:0] ADDR_BITS_24 = 7'h18;
	localparam logic [6:0] ADDR_BITS_32 = 7'h20;
	localparam logic [6:0] PW_BITS = 7'h40;
	localparam logic [6:0] NO_TARGET = 7'h7F;
	localparam logic [4:0] DUMMY_FAST = 5'h08;
	localparam logic [4:0] DUMMY_QIO = 5'h04;

	localparam logic [2:0] LANES_1 = 3'h1;
	localparam logic [2:0] LANES_2 = 3'h2;
	localparam logic [2:0] LANES_4 = 3'h4;

	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_READ4 = 8'h13;
	localparam logic [7:0] OP_FAST = 8'h0B;
	localparam logic [7:0] OP_FAST4 = 8'h0C;
	localparam logic [7:0] OP_DOR = 8'h3B;
	localparam logic [7:0] OP_DOR4 = 8'h3C;
	localparam logic [7:0] OP_QOR = 8'h6B;
	localparam logic [7:0] OP_QOR4 = 8'h6C;
	localparam logic [7:0] OP_DIOR = 8'hBB;
	localparam logic [7:0] OP_DIOR4 = 8'hBC;
	localparam logic [7:0] OP_QIOR = 8'hEB;
	localparam logic [7:0] OP_QIOR4 = 8'hEC;
	localparam logic [7:0] OP_RD_STATUS = 8'h05;
	localparam logic [7:0] OP_CLR_STATUS = 8'h30;
	localparam logic [7:0] OP_SW_RESET = 8'hF0;
	localparam logic [7:0] OP_LOCK_CLR = 8'hA6;
	localparam logic [7:0] OP_PW_PROG = 8'hE8;
	localparam logic [7:0] OP_PW_RD = 8'hE7;
	localparam logic [7:0] OP_PW_UNLOCK = 8'hE9;
	localparam logic [7:0] OP_MODE_PROG = 8'h2F;

	typedef enum logic [3:0] {
		K_NONE = 4'h0, K_ARRAY_RD = 4'h1, K_STATUS_RD = 4'h2, K_PW_RD = 4'h3,
		K_PW_PROG = 4'h4, K_PW_UNLOCK = 4'h5, K_LOCK_CLR = 4'h6, K_MODE_PROG = 4'h7,
		K_CLR_STATUS = 4'h8, K_SW_RESET = 4'h9
	} kind_t;

	typedef enum logic [2:0] {
		PH_START = 3'b000, PH_INSTR = 3'b001, PH_ADDR = 3'b010, PH_MODE = 3'b011,
		PH_DUMMY = 3'b100, PH_OUT = 3'b101, PH_IN = 3'b110, PH_IGNORE = 3'b111
	} phase_t;

	typedef struct packed {
		kind_t kind;
		logic addr_phase;
		logic addr4;
		logic [2:0] addr_lanes;
		logic [2:0] data_lanes;
		logic mode_phase;
		logic [4:0] dummy;
		logic [6:0] in_bits;
	} cmd_attr_t;

	typedef struct packed {
		kind_t kind;
		logic [31:0] addr;
		logic [63:0] data;
	} link_evt_t;

	function automatic cmd_attr_t mk_cmd(input kind_t k, input logic [2:0] al,
			input logic [2:0] dl, input logic md, input logic [4:0] dm, input logic [6:0] ib);
		cmd_attr_t a;
		a.kind = k;
		a.addr_phase = (k == K_ARRAY_RD);
		a.addr4 = 1'b0;
		a.addr_lanes = al;
		a.data_lanes = dl;
		a.mode_phase = md;
		a.dummy = dm;
		a.in_bits = ib;
		return a;
	endfunction

	function automatic cmd_attr_t decode_cmd(input logic [7:0] op);
		cmd_attr_t a;
		a = mk_cmd(K_NONE, LANES_1, LANES_1, 1'b0, 5'h00, 7'h00);
		case (op)
			OP_READ, OP_READ4: a = mk_cmd(K_ARRAY_RD, LANES_1, LANES_1, 1'b0, 5'h00, 7'h00);
			OP_FAST, OP_FAST4: a = mk_cmd(K_ARRAY_RD, LANES_1, LANES_1, 1'b0, DUMMY_FAST, 7'h00);
			OP_DOR, OP_DOR4: a = mk_cmd(K_ARRAY_RD, LANES_1, LANES_2, 1'b0, DUMMY_FAST, 7'h00);
			OP_QOR, OP_QOR4: a = mk_cmd(K_ARRAY_RD, LANES_1, LANES_4, 1'b0, DUMMY_FAST, 7'h00);
			OP_DIOR, OP_DIOR4: a = mk_cmd(K_ARRAY_RD, LANES_2, LANES_2, 1'b1, 5'h00, 7'h00);
			OP_QIOR, OP_QIOR4: a = mk_cmd(K_ARRAY_RD, LANES_4, LANES_4, 1'b1, DUMMY_QIO, 7'h00);
			OP_RD_STATUS: a = mk_cmd(K_STATUS_RD, LANES_1, LANES_1, 1'b0, 5'h00, 7'h00);
			OP_PW_RD: a = mk_cmd(K_PW_RD, LANES_1, LANES_1, 1'b0, 5'h00, 7'h00);
			OP_PW_PROG: a = mk_cmd(K_PW_PROG, LANES_1, LANES_1, 1'b0, 5'h00, PW_BITS);
			OP_PW_UNLOCK: a = mk_cmd(K_PW_UNLOCK, LANES_1, LANES_1, 1'b0, 5'h00, PW_BITS);
			OP_MODE_PROG: a = mk_cmd(K_MODE_PROG, LANES_1, LANES_1, 1'b0, 5'h00, MODE_BITS);
			OP_LOCK_CLR: a = mk_cmd(K_LOCK_CLR, LANES_1, LANES_1, 1'b0, 5'h00, 7'h00);
			OP_CLR_STATUS: a = mk_cmd(K_CLR_STATUS, LANES_1, LANES_1, 1'b0, 5'h00, 7'h00);
			OP_SW_RESET: a = mk_cmd(K_SW_RESET, LANES_1, LANES_1, 1'b0, 5'h00, 7'h00);
			default: a = mk_cmd(K_NONE, LANES_1, LANES_1, 1'b0, 5'h00, 7'h00);
		endcase
		a.addr4 = (op[7:4] == OP_READ4[7:4] && op[3:0] != OP_FAST[3:0]) || op == OP_FAST4
			|| op == OP_DOR4 || op == OP_QOR4 || op == OP_DIOR4 || op == OP_QIOR4;
		return a;
	endfunction

endpackage

// [flash_cmd_frontend.sv]
`timescale 1ns/1ps
// Contract
// - Persistent mode: guard lock reads 1 after power-on or hardware reset.
// - Software reset never touches the guard lock.
// - Lock clear command drops the lock to 0; outside password mode nothing but reset raises it again.
// - Password mode: guard lock reads 0 after power-on or hardware reset.
// - Full 64-bit password match unlocks the guard bits.
// - After password mode is chosen the password can no longer be read.
// - Password programming only turns ones into zeros, never flags an error.
// - Password starts all ones and sits in its own space, own commands only.
// - In password mode password program and read commands are silently dropped.
// - Mode select bits are one-time programmable, never erased.
// - Wrong password: lock unchanged, program error set, busy flag stays set.
// - Unlock attempts spaced by the delay, busy meanwhile; a match skips it.
// - Every command except a continuous-mode frame opens with an 8-bit instruction on data line 0.
// - Address, when present, is 24 or 32 bits.
// - Instruction selects 1, 2 or 4 lanes for the address and mode bits and, separately, for read data.
// - Dual and quad output reads take the address on one line.
// - MSB first; address high byte first; data bytes in rising address order.
// - Mode bits may make the next frame skip its instruction byte.
// - Reads insert the per-command count of dummy clocks before data.
// - While busy, array reads are ignored and only a few commands pass.
// - Chip select low frames the command; raising it ends it.
// - Mode bits 11 default, 10 persistent, 01 password; writing 00 fails.
module flash_cmd_frontend
	import flash_front_pkg::*;
#(
	parameter int UNLOCK_DELAY_CYC = UNLOCK_CYC_DEF
) (
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	input wire logic [1:0] nv_mode_in,
	input wire logic [63:0] nv_password_in,
	input wire logic ext_addr_in,
	input wire logic sck_in,
	input wire logic cs_n_in,
	input wire logic data_line_0_in,
	input wire logic data_line_1_in,
	input wire logic data_line_2_in,
	input wire logic data_line_3_in,
	output logic data_line_0_out,
	output logic data_line_1_out,
	output logic data_line_2_out,
	output logic data_line_3_out,
	output logic data_line_0_oe,
	output logic data_line_1_oe,
	output logic data_line_2_oe,
	output logic data_line_3_oe,
	output logic guard_bits_lock_out,
	output logic write_in_progress_flag_out,
	output logic prog_error_out,
	output logic [1:0] protection_mode_select_reg_out,
	output logic [63:0] password_out,
	output logic nv_write_out,
	output logic array_rd_req_out,
	output logic [31:0] array_rd_addr_out
);

	// Link side, clocked by the host's serial clock
	phase_t ph_q, cur_ph, nph, after_instr, after_addr, after_mode;
	logic [6:0] cnt_q, cnt_n, cnt_d, target, addr_len;
	logic [63:0] sh_q, sh_n, osh_q, out_src;
	logic [7:0] op_q, cur_op, op_n, status_byte;
	logic [31:0] addr_q, addr_n;
	logic [2:0] lanes;
	logic [3:0] din, out_q, oe_q, out_vec, oe_vec;
	cmd_attr_t attr;
	logic frame_start, phase_done, is_out, needs_evt, fire, drive_ok, counting;
	link_evt_t evt_q;
	logic evt_tgl_q, cont_q;
	logic [7:0] cont_op_q;
	logic [3:0] x_s1_q, x_s2_q;
	logic wip_s, perr_s, pwmode_s, ext_s;

	assign din = {data_line_3_in, data_line_2_in, data_line_1_in, data_line_0_in};
	assign {pwmode_s, perr_s, wip_s, ext_s} = x_s2_q;

	// Continuous mode picks the frame up at the address with the stored opcode
	assign frame_start = (ph_q == PH_START);
	assign cur_ph = frame_start ? (cont_q ? PH_ADDR : PH_INSTR) : ph_q;
	assign cur_op = frame_start ? cont_op_q : op_q;
	assign op_n = (cur_ph == PH_INSTR) ? sh_n[7:0] : cur_op;
	assign attr = decode_cmd(op_n);

	// Lane count is fixed by the instruction; dual/quad output keep a 1-line address
	assign lanes = (cur_ph == PH_ADDR || cur_ph == PH_MODE) ? attr.addr_lanes :
		(cur_ph == PH_OUT) ? attr.data_lanes : LANES_1;
	assign sh_n = (lanes == LANES_4) ? {sh_q[59:0], din} :
		(lanes == LANES_2) ? {sh_q[61:0], din[1:0]} : {sh_q[62:0], din[0]};
	assign counting = (cur_ph != PH_OUT) && (cur_ph != PH_IGNORE);
	assign cnt_n = cnt_q + {4'h0, lanes};
	assign addr_len = (attr.addr4 || ext_s) ? ADDR_BITS_32 : ADDR_BITS_24;
	assign addr_n = (addr_len == ADDR_BITS_32) ? sh_n[31:0] : {8'h00, sh_n[23:0]};
	assign target = (cur_ph == PH_INSTR) ? INSTR_BITS :
		(cur_ph == PH_ADDR) ? addr_len :
		(cur_ph == PH_MODE) ? MODE_BITS :
		(cur_ph == PH_DUMMY) ? {2'b00, attr.dummy} :
		(cur_ph == PH_IN) ? attr.in_bits : NO_TARGET;
	assign phase_done = counting && (cnt_n == target);
	assign cnt_d = phase_done ? 7'h00 : (counting ? cnt_n : cnt_q);

	assign is_out = (attr.kind == K_STATUS_RD) || (attr.kind == K_PW_RD) ||
		(attr.kind == K_ARRAY_RD);
	assign after_mode = (attr.dummy != 5'h00) ? PH_DUMMY : (is_out ? PH_OUT : PH_IGNORE);
	assign after_addr = attr.mode_phase ? PH_MODE : after_mode;
	assign after_instr = (attr.kind == K_NONE) ? PH_IGNORE :
		attr.addr_phase ? PH_ADDR :
		(attr.in_bits != 7'h00) ? PH_IN :
		is_out ? after_mode : PH_IGNORE;
	always_comb begin
		nph = cur_ph;
		if (phase_done) begin
			unique case (cur_ph)
				PH_INSTR: nph = after_instr;
				PH_ADDR: nph = after_addr;
				PH_MODE: nph = after_mode;
				PH_DUMMY: nph = PH_OUT;
				PH_IN: nph = PH_IGNORE;
				PH_START, PH_OUT, PH_IGNORE: nph = cur_ph;
			endcase
		end
	end

	assign needs_evt = (attr.kind != K_NONE) && (attr.kind != K_STATUS_RD) &&
		(attr.kind != K_PW_RD);
	assign fire = phase_done && needs_evt && (cur_ph != PH_DUMMY) &&
		(nph != PH_ADDR) && (nph != PH_MODE) && (nph != PH_IN);

	// Password only changes while busy, and a busy device refuses its read,
	// so the 64-bit word is quiet whenever this side samples it
	assign status_byte = (8'(wip_s) << ST_WIP_BIT) | (8'(perr_s) << ST_PERR_BIT);
	assign out_src = (attr.kind == K_STATUS_RD) ? {8{status_byte}} :
		(attr.kind == K_PW_RD) ? password_out : ALL_ONES;

	// Framing state is wiped whenever chip select is high
	always_ff @(posedge sck_in or posedge cs_n_in) begin
		if (cs_n_in) begin
			ph_q <= PH_START;
			cnt_q <= 7'h00;
			sh_q <= 64'h0000_0000_0000_0000;
			op_q <= 8'h00;
			addr_q <= 32'h0000_0000;
			osh_q <= 64'h0000_0000_0000_0000;
		end else begin
			ph_q <= nph;
			cnt_q <= cnt_d;
			sh_q <= sh_n;
			op_q <= op_n;
			if (phase_done && cur_ph == PH_ADDR) begin
				addr_q <= addr_n;
			end
			if (phase_done && nph == PH_OUT) begin
				osh_q <= out_src;
			end else if (cur_ph == PH_OUT) begin
				osh_q <= (lanes == LANES_4) ? {osh_q[59:0], osh_q[63:60]} :
					(lanes == LANES_2) ? {osh_q[61:0], osh_q[63:62]} :
					{osh_q[62:0], osh_q[63]};
			end
		end
	end

	// Survives chip select: event payload, continuous mode, status synchronisers
	always_ff @(posedge sck_in or negedge rstn_in) begin
		if (!rstn_in) begin
			evt_q <= '0;
			evt_tgl_q <= 1'b0;
			cont_q <= 1'b0;
			cont_op_q <= 8'h00;
			x_s1_q <= 4'h0;
			x_s2_q <= 4'h0;
		end else begin
			x_s1_q <= {(protection_mode_select_reg_out == MODE_PASSWORD), prog_error_out,
				write_in_progress_flag_out, ext_addr_in};
			x_s2_q <= x_s1_q;
			if (fire) begin
				evt_q.kind <= attr.kind;
				evt_q.addr <= (cur_ph == PH_ADDR) ? addr_n : addr_q;
				evt_q.data <= sh_n;
				evt_tgl_q <= ~evt_tgl_q;
			end
			if (phase_done && cur_ph == PH_MODE) begin
				cont_q <= (sh_n[7:4] == CONT_MODE_CODE);
				cont_op_q <= op_n;
			end
		end
	end

	// Busy device leaves array and password reads undriven
	assign drive_ok = (attr.kind == K_STATUS_RD) ||
		((attr.kind == K_PW_RD) && !pwmode_s && !wip_s) ||
		((attr.kind == K_ARRAY_RD) && !wip_s);
	assign oe_vec = (attr.data_lanes == LANES_4) ? 4'hF :
		(attr.data_lanes == LANES_2) ? 4'h3 : 4'h2;
	assign out_vec = (attr.data_lanes == LANES_4) ? osh_q[63:60] :
		(attr.data_lanes == LANES_2) ? {2'b00, osh_q[63:62]} : {2'b00, osh_q[63], 1'b0};

	// Launch on the falling edge so the host samples on the rising one
	always_ff @(negedge sck_in or posedge cs_n_in) begin
		if (cs_n_in) begin
			oe_q <= 4'h0;
			out_q <= 4'h0;
		end else begin
			oe_q <= (ph_q == PH_OUT && drive_ok) ? oe_vec : 4'h0;
			out_q <= out_vec;
		end
	end

	assign {data_line_3_out, data_line_2_out, data_line_1_out, data_line_0_out} = out_q;
	assign {data_line_3_oe, data_line_2_oe, data_line_1_oe, data_line_0_oe} = oe_q;

	// System side
	logic [2:0] tgl_sync_q;
	logic evt_pulse, wip_q, wip_d, lock_q, lock_d, perr_q, perr_d, hold_q, hold_d;
	logic nvw_q, nvw_d, rdreq_q, rdreq_d;
	logic [1:0] mode_q, mode_d, new_mode;
	logic [63:0] pw_q, pw_d;
	logic [7:0] busy_q, busy_d;
	logic [RATE_W-1:0] rate_q, rate_d;
	logic [31:0] rdaddr_q, rdaddr_d;
	logic idle, pw_match;

	assign evt_pulse = tgl_sync_q[1] ^ tgl_sync_q[2];
	assign idle = (busy_q == 8'h00) && (rate_q == '0);
	assign new_mode = evt_q.data[MODE_SEL_POS +: 2];
	assign pw_match = (evt_q.data == pw_q);

	always_comb begin
		mode_d = mode_q;
		pw_d = pw_q;
		lock_d = lock_q;
		perr_d = perr_q;
		hold_d = hold_q;
		busy_d = (busy_q != 8'h00) ? busy_q - 8'h01 : 8'h00;
		rate_d = (rate_q != '0) ? rate_q - RATE_W'(1) : rate_q;
		nvw_d = 1'b0;
		rdreq_d = 1'b0;
		rdaddr_d = rdaddr_q;
		if (evt_pulse) begin
			case (evt_q.kind)
				K_LOCK_CLR: if (!wip_q) begin
					lock_d = 1'b0;
					busy_d = PROG_CYC;
				end
				K_PW_PROG: if (!wip_q && mode_q != MODE_PASSWORD) begin
					pw_d = pw_q & evt_q.data;
					nvw_d = 1'b1;
					busy_d = PROG_CYC;
				end
				K_MODE_PROG: if (!wip_q && mode_q == MODE_DEFAULT) begin
					if (new_mode == MODE_ILLEGAL) begin
						perr_d = 1'b1;
						hold_d = 1'b1;
					end else begin
						mode_d = new_mode;
						nvw_d = 1'b1;
						busy_d = PROG_CYC;
					end
				end
				K_PW_UNLOCK: if (!wip_q && mode_q == MODE_PASSWORD) begin
					if (pw_match) begin
						lock_d = 1'b1;
					end else begin
						perr_d = 1'b1;
						hold_d = 1'b1;
						rate_d = RATE_W'(UNLOCK_DELAY_CYC);
					end
				end
				K_CLR_STATUS, K_SW_RESET: if (idle) begin
					perr_d = 1'b0;
					hold_d = 1'b0;
				end
				K_ARRAY_RD: if (!wip_q) begin
					rdreq_d = 1'b1;
					rdaddr_d = evt_q.addr;
				end
				default: ;
			endcase
		end
		wip_d = (busy_d != 8'h00) || hold_d || (rate_d != '0);
	end

	// Nonvolatile contents are reloaded from the store on every hardware reset
	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			tgl_sync_q <= 3'h0;
			mode_q <= nv_mode_in;
			pw_q <= nv_password_in;
			lock_q <= (nv_mode_in != MODE_PASSWORD);
			perr_q <= 1'b0;
			hold_q <= 1'b0;
			wip_q <= 1'b0;
			busy_q <= 8'h00;
			rate_q <= '0;
			nvw_q <= 1'b0;
			rdreq_q <= 1'b0;
			rdaddr_q <= 32'h0000_0000;
		end else begin
			tgl_sync_q <= {tgl_sync_q[1:0], evt_tgl_q};
			mode_q <= mode_d;
			pw_q <= pw_d;
			lock_q <= lock_d;
			perr_q <= perr_d;
			hold_q <= hold_d;
			wip_q <= wip_d;
			busy_q <= busy_d;
			rate_q <= rate_d;
			nvw_q <= nvw_d;
			rdreq_q <= rdreq_d;
			rdaddr_q <= rdaddr_d;
		end
	end

	assign guard_bits_lock_out = lock_q;
	assign write_in_progress_flag_out = wip_q;
	assign prog_error_out = perr_q;
	assign protection_mode_select_reg_out = mode_q;
	assign password_out = pw_q;
	assign nv_write_out = nvw_q;
	assign array_rd_req_out = rdreq_q;
	assign array_rd_addr_out = rdaddr_q;

	logic unlock_try;
	assign unlock_try = evt_pulse && evt_q.kind == K_PW_UNLOCK && !wip_q &&
		mode_q == MODE_PASSWORD;

	a_lock_reset_val: assert property (@(posedge clk_sys_in)
		$rose(rstn_in) |-> lock_q == (mode_q != MODE_PASSWORD))
		else $error("lock reset value wrong for mode");
	a_lock_no_reset: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(!lock_q && mode_q != MODE_PASSWORD) |=> !lock_q)
		else $error("lock raised outside password unlock");
	a_lock_clear_cmd: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(evt_pulse && evt_q.kind == K_LOCK_CLR && !wip_q) |=> !lock_q && wip_q)
		else $error("lock clear did not take effect");
	a_swreset_lock: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(evt_pulse && evt_q.kind == K_SW_RESET) |=> lock_q == $past(lock_q))
		else $error("software reset changed lock");
	a_unlock_match: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(unlock_try && pw_match) |=> lock_q && !wip_q && !perr_q)
		else $error("matching password did not unlock at once");
	a_unlock_miss: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(unlock_try && !pw_match) |=> perr_q && wip_q && lock_q == $past(lock_q)
		&& rate_q == RATE_W'(UNLOCK_DELAY_CYC))
		else $error("mismatch handling wrong");
	a_rate_busy: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(rate_q != '0) |-> wip_q ##1 wip_q)
		else $error("busy dropped during unlock delay");
	a_pw_ones_stay: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		$past(rstn_in) |-> (pw_q & ~$past(pw_q)) == 64'h0)
		else $error("password bit went from 0 to 1");
	a_pw_mode_frozen: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(mode_q == MODE_PASSWORD) |=> $stable(pw_q) && mode_q == MODE_PASSWORD)
		else $error("password changed in password mode");
	a_mode_otp: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(mode_q != MODE_DEFAULT) |=> $stable(mode_q) && mode_q != MODE_ILLEGAL)
		else $error("mode bits changed after selection");
	a_busy_no_read: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(evt_pulse && evt_q.kind == K_ARRAY_RD && wip_q) |=> !rdreq_q)
		else $error("array read passed while busy");

	c_unlock_ok: cover property (@(posedge clk_sys_in) disable iff (!rstn_in)
		unlock_try && pw_match);
	c_unlock_bad: cover property (@(posedge clk_sys_in) disable iff (!rstn_in)
		unlock_try && !pw_match);
	c_array_read: cover property (@(posedge clk_sys_in) disable iff (!rstn_in) rdreq_q);
	c_mode_prog: cover property (@(posedge clk_sys_in) disable iff (!rstn_in)
		nvw_q && mode_q == MODE_PASSWORD);

endmodule

// [host_spi_model.sv]
`timescale 1ns/1ps
module host_spi_model (
	output logic sck_out,
	output logic cs_n_out,
	output logic [3:0] io_out,
	output logic [3:0] io_en_out,
	input wire logic [3:0] line_in
);
	initial begin
		sck_out = 1'b0;
		cs_n_out = 1'b1;
		io_out = 4'h0;
		io_en_out = 4'h1;
	end
	// One 6 ns clock period; read bits are taken at the rising edge, w lines wide
	task automatic tick(input logic [3:0] d, input logic [3:0] en, input int w, input bit smp,
			inout logic [63:0] rx);
		io_out = d;
		io_en_out = en;
		#3 sck_out = 1'b1;
		if (smp)
			rx = (w == 4) ? {rx[59:0], line_in} :
				((w == 2) ? {rx[61:0], line_in[1:0]} : {rx[62:0], line_in[1]});
		#3 sck_out = 1'b0;
	endtask
	// Clock runs only inside a frame: the top n - nw bits go on line 0, the last nw bits
	// go w lines wide, then rd read clocks follow with every line released
	task automatic frame(input logic [127:0] v, input int n, input int nw, input int w,
			input int rd, output logic [63:0] rx);
		logic [3:0] wen;
		wen = (w == 4) ? 4'hF : ((w == 2) ? 4'h3 : 4'h1);
		rx = '0;
		cs_n_out = 1'b0;
		#3;
		for (int i = n - 1; i >= nw; i--)
			tick({3'b000, v[i]}, 4'h1, w, 1'b0, rx);
		for (int i = nw - w; i >= 0; i -= w)
			tick(v[i+:4] & wen, wen, w, 1'b0, rx);
		for (int k = 0; k < rd; k++)
			tick(4'h0, 4'h0, w, 1'b1, rx);
		#3 cs_n_out = 1'b1;
		io_en_out = 4'h1;
		#6;
	endtask
endmodule

// [serial_flash_cmd_frontend_pw_lock_tb.sv]
`timescale 1ns/1ps
module serial_flash_cmd_frontend_pw_lock_tb;
	import flash_front_pkg::*;
	localparam logic [63:0] PW = 64'h0123_4567_89AB_CDEF;
	// Long enough that a clear-status and a retry both land inside the delay
	localparam int UNLOCK_SIM = 200;
	logic clk_sys_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [1:0] nv_mode = 2'h3;
	logic [63:0] nv_pw = ALL_ONES;
	logic ext_addr = 1'b0;
	logic sck, cs_n;
	logic [3:0] h_io, h_en;
	logic tgl = 1'b0;
	logic oe_seen = 1'b0;
	logic [3:0] d_out, d_oe, line;
	logic lock, write_in_progress_flag, perr, nvw, rd_req;
	logic [1:0] mode;
	logic [63:0] pw_out, rx;
	logic [31:0] rd_addr;
	int errors = 0;
	int checked = 0;
	int cycles = 0;
	int nreq = 0;
	int nwr = 0;

	// Released lines toggle so a stale value never reads as data
	assign line = (d_oe & d_out) | (~d_oe & h_en & h_io) | (~d_oe & ~h_en & {4{tgl}});
	always @(negedge sck) tgl <= ~tgl;
	always #4 clk_sys_in = ~clk_sys_in;

	host_spi_model host_spi_model_i (.sck_out(sck), .cs_n_out(cs_n), .io_out(h_io),
		.io_en_out(h_en), .line_in(line));

	flash_cmd_frontend #(.UNLOCK_DELAY_CYC(UNLOCK_SIM)) flash_cmd_frontend_i (
		.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .nv_mode_in(nv_mode),
		.nv_password_in(nv_pw), .ext_addr_in(ext_addr), .sck_in(sck), .cs_n_in(cs_n),
		.data_line_0_in(line[0]), .data_line_1_in(line[1]), .data_line_2_in(line[2]),
		.data_line_3_in(line[3]), .data_line_0_out(d_out[0]), .data_line_1_out(d_out[1]),
		.data_line_2_out(d_out[2]), .data_line_3_out(d_out[3]), .data_line_0_oe(d_oe[0]),
		.data_line_1_oe(d_oe[1]), .data_line_2_oe(d_oe[2]), .data_line_3_oe(d_oe[3]),
		.guard_bits_lock_out(lock), .write_in_progress_flag_out(write_in_progress_flag), .prog_error_out(perr),
		.protection_mode_select_reg_out(mode), .password_out(pw_out), .nv_write_out(nvw),
		.array_rd_req_out(rd_req), .array_rd_addr_out(rd_addr));

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	always @(posedge clk_sys_in) begin
		cycles++;
		if (rd_req === 1'b1)
			nreq++;
		if (nvw === 1'b1)
			nwr++;
		if (d_oe[1] === 1'b1)
			oe_seen = 1'b1;
		if (cycles == 20000) begin
			errors++;
			$display("MISMATCH timeout expected 0 seen 1");
			summarize();
		end
	end

	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask

	// Commands act on the third system clock edge after their last bit
	task automatic send(input logic [127:0] v, input int n, input int rd);
		send_w(v, n, 0, 1, rd);
	endtask

	task automatic send_w(input logic [127:0] v, input int n, input int nw, input int w,
			input int rd);
		host_spi_model_i.frame(v, n, nw, w, rd, rx);
		settle(8);
	endtask

	task automatic idle();
		for (int i = 0; i < 300 && write_in_progress_flag !== 1'b0; i++)
			settle(1);
		chk("wip idle", 0, write_in_progress_flag);
	endtask

	task automatic rst(input logic [1:0] m, input logic [63:0] p);
		rstn_in = 1'b0;
		nv_mode = m;
		nv_pw = p;
		settle(10);
		rstn_in = 1'b1;
		settle(2);
	endtask

	initial begin
		rst(MODE_DEFAULT, ALL_ONES);
		chk("lock", 1, lock);
		chk("password", ALL_ONES, pw_out);
		send(OP_RD_STATUS, 8, 8);
		chk("status", 0, rx);
		send(OP_LOCK_CLR, 8, 0);
		chk("lock", 0, lock);
		chk("wip", 1, write_in_progress_flag);
		send({OP_READ, 24'h12_3456}, 32, 8);
		chk("busy read", 0, nreq);
		idle();
		send(OP_SW_RESET, 8, 0);
		chk("lock", 0, lock);
		$display("test lock done");
		send({OP_READ, 24'h12_3456}, 32, 8);
		chk("read addr", 32'h0012_3456, rd_addr);
		send({OP_FAST4, 32'hFEDC_BA98}, 40, 16);
		chk("read4 addr", 32'hFEDC_BA98, rd_addr);
		chk("read data", 8'hFF, rx[7:0]);
		chk("read count", 2, nreq);
		ext_addr = 1'b1;
		send({OP_READ, 32'h89AB_CDEF}, 40, 8);
		chk("ext addr", 32'h89AB_CDEF, rd_addr);
		ext_addr = 1'b0;
		send_w({OP_QOR, 24'h00_0040}, 32, 0, 4, 10);
		chk("quad out addr", 32'h0000_0040, rd_addr);
		chk("quad data", 8'hFF, rx[7:0]);
		send_w({OP_DIOR, 24'h65_4321, 8'hA0}, 40, 32, 2, 4);
		chk("dual io addr", 32'h0065_4321, rd_addr);
		chk("dual io data", 8'hFF, rx[7:0]);
		send_w({24'h00_1357, 8'h00}, 32, 32, 2, 4);
		chk("cont addr", 32'h0000_1357, rd_addr);
		chk("read count", 6, nreq);
		$display("test multi lane done");
		send({OP_PW_PROG, PW}, 72, 0);
		idle();
		chk("password", PW, pw_out);
		send({OP_PW_PROG, ALL_ONES}, 72, 0);
		idle();
		chk("password", PW, pw_out);
		chk("perr", 0, perr);
		send(OP_PW_RD, 8, 64);
		chk("password read", PW, rx);
		send({OP_MODE_PROG, 8'h04}, 16, 0);
		idle();
		chk("mode", MODE_PERSIST, mode);
		send({OP_MODE_PROG, 8'h02}, 16, 0);
		idle();
		chk("mode", MODE_PERSIST, mode);
		rst(MODE_DEFAULT, ALL_ONES);
		send({OP_MODE_PROG, 8'h00}, 16, 0);
		chk("illegal mode perr", 1, perr);
		rst(MODE_DEFAULT, PW);
		send({OP_MODE_PROG, 8'h02}, 16, 0);
		chk("mode", MODE_PASSWORD, mode);
		chk("nv writes", 4, nwr);
		$display("test password program done");
		rst(MODE_PASSWORD, PW);
		chk("lock", 0, lock);
		oe_seen = 1'b0;
		send(OP_PW_RD, 8, 64);
		chk("password driven", 0, oe_seen);
		send({OP_PW_PROG, 64'h0}, 72, 0);
		chk("password", PW, pw_out);
		send({OP_PW_UNLOCK, ~PW}, 72, 0);
		chk("lock", 0, lock);
		send(OP_RD_STATUS, 8, 8);
		chk("status", 8'h41, rx);
		send(OP_CLR_STATUS, 8, 0);
		chk("wip held", 1, write_in_progress_flag);
		send({OP_PW_UNLOCK, PW}, 72, 0);
		chk("lock in delay", 0, lock);
		settle(UNLOCK_SIM);
		send(OP_CLR_STATUS, 8, 0);
		chk("wip", 0, write_in_progress_flag);
		send({OP_PW_UNLOCK, PW}, 72, 0);
		chk("lock", 1, lock);
		chk("wip", 0, write_in_progress_flag);
		$display("test unlock done");
		summarize();
	end
endmodule
